// ===== core/tflr_pkg.sv
// package with command codes, fields, reset values and types
package tflr_pkg;
    // command codes of the limit and policy registers
    localparam logic [7:0] CODE_OT_WARN = 8'h51;
    localparam logic [7:0] CODE_UT_WARN = 8'h52;
    localparam logic [7:0] CODE_UT_FAULT = 8'h53;
    localparam logic [7:0] CODE_UT_POLICY = 8'h54;
    // policy byte field positions
    localparam int MODE_HI = 7;
    localparam int MODE_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam int DELAY_HI = 2;
    localparam int DELAY_LO = 0;
    // response modes and retry codes
    localparam logic [1:0] MODE_IGNORE = 2'h0;
    localparam logic [1:0] MODE_RUN_DELAY = 2'h1;
    localparam logic [1:0] MODE_OFF_RETRY = 2'h2;
    localparam logic [1:0] MODE_LATCH = 2'h3;
    localparam logic [2:0] RETRY_NONE = 3'h0;
    localparam logic [2:0] RETRY_FOREVER = 3'h7;
    // reset values
    localparam logic [15:0] RST_OT_WARN = 16'h0000;
    localparam logic [15:0] RST_UT_WARN = 16'h0000;
    localparam logic [15:0] RST_UT_FAULT = 16'h0000;
    localparam logic [7:0] RST_UT_POLICY = 8'h00;
    // linear format layout
    localparam int LIN_EXP_HI = 15;
    localparam int LIN_EXP_LO = 11;
    localparam int LIN_FRAC_BITS = 16;
    // command request from the management link decoder
    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] code;
        logic [15:0] data;
    } tflr_cmd_t;
    // reply to a read request
    typedef struct packed {
        logic valid;
        logic unmapped;
        logic [15:0] data;
    } tflr_rsp_t;
    // fault handling states, gray along run-delay-wait-latch
    typedef enum logic [1:0] {
        ST_RUN = 2'h0,
        ST_DELAY = 2'h1,
        ST_WAIT = 2'h3,
        ST_LATCH = 2'h2
    } tflr_state_t;
endpackage

// ===== core/tflr_top.sv
// temperature limits and under-temperature fault response logic
`timescale 1ns/1ps
// What this block does
// - delay field n means 2**n time units, 1 to 128.
// - time unit length comes from a separate unit tick, not this byte.
// - one delay count serves keep-running time and restart spacing.
// - sixteen-bit over-temperature warning limit, read and write, word.
// - sixteen-bit under-temperature warning limit, read and write, word.
// - sixteen-bit under-temperature fault limit, read and write, word.
// - policy byte holds mode, retry count and delay count.
// - mode 00 keeps regulating through the fault.
// - mode 01 runs for the delay, then follows retries if still faulted.
// - mode 10 turns output off at once, then follows retries.
// - mode 11 keeps output off until the fault is cleared.
// - retry count 000 means no restart, off until cleared.
// - counts 1 to 6 allow that many restarts, then off until cleared.
// - count 111 retries without limit until commanded off.
module tflr_top (
    input wire logic mclk,
    input wire logic sys_rst,
    input tflr_pkg::tflr_cmd_t cmdReq,
    output tflr_pkg::tflr_rsp_t cmdRsp,
    input wire logic [15:0] tempReading,
    input wire logic unitTick,
    input wire logic clearFaults,
    input wire logic clearStatusBit,
    input wire logic onCommand,
    output logic outputEnable,
    output logic utFaultStatus,
    output logic utWarnStatus,
    output logic otWarnStatus,
    output logic [2:0] retriesUsed
);
    import tflr_pkg::*;

    logic [15:0] otWarnLimit;
    logic [15:0] utWarnLimit;
    logic [15:0] utFaultLimit;
    logic [7:0] utPolicy;
    tflr_state_t state;
    tflr_state_t next_state;
    logic [7:0] unitCount;
    logic [7:0] delayTarget;
    logic delayDone;
    logic faultNow;
    logic utWarnNow;
    logic otWarnNow;
    logic clearNow;
    logic failNow;
    logic onPrev;
    logic [1:0] mode;
    logic [2:0] retryLimit;

    // linear word to signed fixed point with sixteen fraction bits
    function automatic logic signed [47:0] lin_to_fix(input logic [15:0] w);
        logic signed [4:0] expo;
        logic signed [47:0] mant;
        logic [5:0] sh;
        expo = w[LIN_EXP_HI:LIN_EXP_LO];
        mant = 48'(signed'(w[10:0]));
        // signed sum, so a negative exponent shortens the shift
        sh = 6'(int'(expo) + LIN_FRAC_BITS);
        lin_to_fix = mant <<< sh;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register writes from the management link
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            otWarnLimit <= RST_OT_WARN;
            utWarnLimit <= RST_UT_WARN;
            utFaultLimit <= RST_UT_FAULT;
            utPolicy <= RST_UT_POLICY;
        end else if (cmdReq.valid && cmdReq.write) begin
            case (cmdReq.code)
                CODE_OT_WARN: otWarnLimit <= cmdReq.data;
                CODE_UT_WARN: utWarnLimit <= cmdReq.data;
                CODE_UT_FAULT: utFaultLimit <= cmdReq.data;
                CODE_UT_POLICY: utPolicy <= cmdReq.data[7:0];
                default: ;
            endcase
        end
    end

    // registered read replies, unmapped codes read zero and flag it
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cmdRsp <= '0;
        end else begin
            cmdRsp.valid <= cmdReq.valid && !cmdReq.write;
            cmdRsp.unmapped <= 1'b0;
            case (cmdReq.code)
                CODE_OT_WARN: cmdRsp.data <= otWarnLimit;
                CODE_UT_WARN: cmdRsp.data <= utWarnLimit;
                CODE_UT_FAULT: cmdRsp.data <= utFaultLimit;
                CODE_UT_POLICY: cmdRsp.data <= {8'h00, utPolicy};
                default: begin
                    cmdRsp.data <= 16'h0000;
                    cmdRsp.unmapped <= cmdReq.valid;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // policy fields and threshold compares
    assign mode = utPolicy[MODE_HI:MODE_LO];
    assign retryLimit = utPolicy[RETRY_HI:RETRY_LO];
    assign delayTarget = 8'h01 << utPolicy[DELAY_HI:DELAY_LO];
    assign faultNow = lin_to_fix(tempReading) < lin_to_fix(utFaultLimit);
    assign utWarnNow = lin_to_fix(tempReading) < lin_to_fix(utWarnLimit);
    assign otWarnNow = lin_to_fix(tempReading) > lin_to_fix(otWarnLimit);
    assign clearNow = clearFaults || clearStatusBit || (onCommand && !onPrev);
    assign delayDone = unitTick && (unitCount == 8'(delayTarget - 8'h01));

    // sticky status flags, a new event wins over a clear
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            utFaultStatus <= 1'b0;
            utWarnStatus <= 1'b0;
            otWarnStatus <= 1'b0;
        end else begin
            utFaultStatus <= faultNow || (utFaultStatus && !clearNow);
            utWarnStatus <= utWarnNow || (utWarnStatus && !clearNow);
            otWarnStatus <= otWarnNow || (otWarnStatus && !clearNow);
        end
    end

    // remembers the on command to see an off-then-on cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            onPrev <= 1'b0;
        end else begin
            onPrev <= onCommand;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // delay counter in time units, shared by run delay and restart wait
    always_ff @(posedge mclk) begin
        if (sys_rst || next_state != state) begin
            unitCount <= 8'h00;
        end else if ((state == ST_DELAY || state == ST_WAIT) && unitTick) begin
            unitCount <= delayDone ? 8'h00 : 8'(unitCount + 8'h01);
        end
    end

    // a fault that ends a run or a restart attempt
    always_comb begin
        failNow = 1'b0;
        if (onCommand && faultNow) begin
            if (state == ST_RUN) begin
                failNow = (mode == MODE_OFF_RETRY);
            end else if (state == ST_DELAY) begin
                failNow = delayDone;
            end
        end
    end

    // next state of the fault response
    always_comb begin
        next_state = state;
        if (!onCommand) begin
            next_state = ST_RUN;
        end else begin
            case (state)
                ST_RUN: begin
                    if (faultNow && mode == MODE_RUN_DELAY) begin
                        next_state = ST_DELAY;
                    end else if (faultNow && mode == MODE_LATCH) begin
                        next_state = ST_LATCH;
                    end
                end
                ST_DELAY: begin
                    if (delayDone && !faultNow) begin
                        next_state = ST_RUN;
                    end
                end
                ST_WAIT: begin
                    // a clear also ends the wait, with the count reset
                    if (delayDone || clearNow) begin
                        next_state = ST_RUN;
                    end
                end
                ST_LATCH: begin
                    if (clearNow) begin
                        next_state = ST_RUN;
                    end
                end
                default: next_state = ST_RUN;
            endcase
            if (failNow) begin
                if (retryLimit == RETRY_NONE) begin
                    next_state = ST_LATCH;
                end else if (retryLimit == RETRY_FOREVER) begin
                    next_state = ST_WAIT;
                end else if (retriesUsed < retryLimit) begin
                    next_state = ST_WAIT;
                end else begin
                    next_state = ST_LATCH;
                end
            end
        end
    end

    // state register
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // restart attempts spent since the fault was last cleared
    always_ff @(posedge mclk) begin
        if (sys_rst || !onCommand || clearNow) begin
            retriesUsed <= 3'h0;
        end else if (failNow && next_state == ST_WAIT
                     && retryLimit != RETRY_FOREVER) begin
            retriesUsed <= 3'(retriesUsed + 3'h1);
        end
    end

    // output is on while running or riding out the delay
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            outputEnable <= 1'b0;
        end else begin
            outputEnable <= (next_state == ST_RUN || next_state == ST_DELAY)
                            && onCommand;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);

    property p_ignore_keeps_on;
        state == ST_RUN && mode == MODE_IGNORE && onCommand && faultNow
            ##1 onCommand |-> outputEnable;
    endproperty
    a_ignore_keeps_on: assert property (p_ignore_keeps_on)
        else $error("mode 00 fault interrupted output");

    property p_delay_runs;
        state == ST_RUN && mode == MODE_RUN_DELAY && onCommand && faultNow
            |=> state == ST_DELAY && outputEnable;
    endproperty
    a_delay_runs: assert property (p_delay_runs)
        else $error("mode 01 did not keep running");

    property p_off_at_once;
        state == ST_RUN && mode == MODE_OFF_RETRY && onCommand && faultNow
            |=> !outputEnable;
    endproperty
    a_off_at_once: assert property (p_off_at_once)
        else $error("mode 10 did not disable output");

    property p_latch_holds;
        state == ST_LATCH && onCommand && !clearNow
            |=> state == ST_LATCH && !outputEnable;
    endproperty
    a_latch_holds: assert property (p_latch_holds)
        else $error("latched off state left without clear");

    property p_no_retry;
        failNow && retryLimit == RETRY_NONE |=> state == ST_LATCH;
    endproperty
    a_no_retry: assert property (p_no_retry)
        else $error("retry count 000 restarted");

    property p_retry_bound;
        state == ST_WAIT && retryLimit != RETRY_FOREVER
            |-> retriesUsed <= retryLimit && retriesUsed != 3'h0;
    endproperty
    a_retry_bound: assert property (p_retry_bound)
        else $error("restart attempts exceed retry count");

    property p_forever;
        failNow && retryLimit == RETRY_FOREVER |=> state == ST_WAIT;
    endproperty
    a_forever: assert property (p_forever)
        else $error("continuous retry stopped");

    property p_unit_bound;
        state == ST_DELAY || state == ST_WAIT |-> unitCount < delayTarget;
    endproperty
    a_unit_bound: assert property (p_unit_bound)
        else $error("delay count passed its target");

    property p_wait_restart;
        state == ST_WAIT && delayDone && onCommand |=> outputEnable;
    endproperty
    a_wait_restart: assert property (p_wait_restart)
        else $error("restart not attempted after delay");

    property p_limit_write;
        cmdReq.valid && cmdReq.write && cmdReq.code == CODE_OT_WARN
            |=> otWarnLimit == $past(cmdReq.data);
    endproperty
    a_limit_write: assert property (p_limit_write)
        else $error("warning limit write lost");

    property p_fault_sticky;
        faultNow |=> utFaultStatus;
    endproperty
    a_fault_sticky: assert property (p_fault_sticky)
        else $error("fault flag not set");
endmodule // tflr_top

// ===== testbench/tflr_host_model.sv
// management host model issuing limit and policy commands
`timescale 1ns/1ps
module tflr_host_model (
    input wire logic mclk,
    output tflr_pkg::tflr_cmd_t cmdReq,
    input tflr_pkg::tflr_rsp_t cmdRsp
);
    import tflr_pkg::*;
    ////////////////////////////////////////////////////////////////////////
    // link idle from time zero
    initial begin
        cmdReq = '0;
    end
    // one write, held across the edge that takes it
    task automatic wr(input logic [7:0] code, input logic [15:0] data);
        @(negedge mclk);
        cmdReq = '{valid: 1'b1, write: 1'b1, code: code, data: data};
        @(negedge mclk);
        cmdReq.valid = 1'b0;
        cmdReq.data = ~data; // stale data must not look valid
    endtask
    // one read; the reply stands in the cycle after the request
    task automatic rd(input logic [7:0] code, output tflr_rsp_t rsp);
        @(negedge mclk);
        cmdReq = '{valid: 1'b1, write: 1'b0, code: code, data: 16'hA5A5};
        @(negedge mclk);
        rsp = cmdRsp;
        cmdReq.valid = 1'b0;
    endtask
endmodule // tflr_host_model

// ===== testbench/tb_top.sv
// self-checking bench for the temperature limits and fault response
`timescale 1ns/1ps
module tb_top;
    import tflr_pkg::*;
    localparam logic [15:0] T_OK = 16'h0014;
    localparam logic [15:0] T_HOT = 16'h0050;
    localparam logic [15:0] T_COOL = 16'h0006;
    localparam logic [15:0] T_COLD = 16'h0001;
    logic mclk, sys_rst, unitTick, clearFaults, clearStatusBit, onCommand;
    tflr_cmd_t cmdReq;
    tflr_rsp_t cmdRsp;
    logic [15:0] tempReading, restarts;
    logic outputEnable, utFaultStatus, utWarnStatus, otWarnStatus;
    logic [2:0] retriesUsed;
    int err_total, comparisons;
    ////////////////////////////////////////////////////////////////////////
    // design and host
    tflr_top dut (.mclk(mclk), .sys_rst(sys_rst), .cmdReq(cmdReq),
        .cmdRsp(cmdRsp), .tempReading(tempReading), .unitTick(unitTick),
        .clearFaults(clearFaults), .clearStatusBit(clearStatusBit),
        .onCommand(onCommand), .outputEnable(outputEnable),
        .utFaultStatus(utFaultStatus), .utWarnStatus(utWarnStatus),
        .otWarnStatus(otWarnStatus), .retriesUsed(retriesUsed));
    tflr_host_model host (.mclk(mclk), .cmdReq(cmdReq), .cmdRsp(cmdRsp));
    // 50 MHz clock
    initial mclk = 1'b0;
    always #10 mclk = ~mclk;
    // counts restart attempts seen at the output
    always @(posedge outputEnable) restarts = restarts + 16'h0001;
    ////////////////////////////////////////////////////////////////////////
    // compare and drive helpers
    task chk_word(input string nm, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask
    task chk_bit(input string nm, input logic e, input logic g);
        chk_word(nm, {15'h0000, e}, {15'h0000, g});
    endtask
    task cycles(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk);
        s = 1'b1;
        @(negedge mclk);
        s = 1'b0;
    endtask
    task ticks(input int n);
        repeat (n) begin
            pulse(unitTick);
            cycles(3);
        end
    endtask
    task policy(input logic [1:0] m, input logic [2:0] r, input logic [2:0] d);
        host.wr(CODE_UT_POLICY, {8'h00, m, r, d});
        restarts = 16'h0000;
    endtask
    task recover;
        tempReading = T_OK;
        pulse(clearFaults);
        cycles(3);
        chk_bit("enable after clear", 1'b1, outputEnable);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // scenarios
    task test_regs;
        tflr_rsp_t rsp;
        logic [7:0] cd[4];
        logic [15:0] v[4];
        cd = '{CODE_OT_WARN, CODE_UT_WARN, CODE_UT_FAULT, CODE_UT_POLICY};
        v = '{16'h8123, 16'hF7FE, 16'h0401, 16'hABCD};
        for (int i = 0; i < 4; i++) begin
            host.rd(cd[i], rsp);
            chk_word("reset value", 16'h0000, rsp.data);
            host.wr(cd[i], v[i]);
        end
        for (int i = 0; i < 4; i++) begin
            host.rd(cd[i], rsp);
            chk_bit("read valid", 1'b1, rsp.valid);
            chk_word("readback", (i == 3) ? 16'h00CD : v[i], rsp.data);
        end
        host.wr(8'h60, 16'h1234);
        host.rd(8'h60, rsp);
        chk_bit("unmapped", 1'b1, rsp.unmapped);
        chk_word("unmapped data", 16'h0000, rsp.data);
        host.wr(CODE_OT_WARN, 16'h0040);
        host.wr(CODE_UT_WARN, 16'h0008);
        host.wr(CODE_UT_FAULT, 16'hF80A); // five as ten halves
    endtask
    task test_ignore;
        policy(MODE_IGNORE, 3'h0, 3'h0);
        recover;
        tempReading = T_HOT;
        cycles(3);
        chk_bit("over warn", 1'b1, otWarnStatus);
        tempReading = T_COOL;
        cycles(3);
        chk_bit("under warn", 1'b1, utWarnStatus);
        chk_bit("no fault", 1'b0, utFaultStatus);
        chk_bit("warn keeps on", 1'b1, outputEnable);
        tempReading = T_COLD;
        ticks(5);
        chk_bit("fault flag", 1'b1, utFaultStatus);
        chk_bit("ignore on", 1'b1, outputEnable);
        chk_word("ignore restarts", 16'h0000, restarts);
        recover;
        chk_bit("flag cleared", 1'b0, utFaultStatus);
    endtask
    task test_run_delay;
        policy(MODE_RUN_DELAY, RETRY_NONE, 3'h2);
        tempReading = T_COLD;
        cycles(3);
        ticks(3);
        chk_bit("still running", 1'b1, outputEnable);
        ticks(1);
        chk_bit("off after delay", 1'b0, outputEnable);
        ticks(4);
        chk_word("no restart", 16'h0000, restarts);
        recover;
    endtask
    task test_delay_retry;
        policy(MODE_RUN_DELAY, 3'h1, 3'h0);
        tempReading = T_COLD;
        cycles(2);
        chk_bit("delay on", 1'b1, outputEnable);
        ticks(1);
        chk_bit("delay then off", 1'b0, outputEnable);
        ticks(1);
        chk_word("delay restart", 16'h0001, restarts);
        chk_bit("rides delay again", 1'b1, outputEnable);
        ticks(1);
        chk_bit("retry spent", 1'b0, outputEnable);
        recover;
    endtask
    task test_off_retry;
        policy(MODE_OFF_RETRY, 3'h2, 3'h1);
        tempReading = T_COLD;
        cycles(2);
        chk_bit("off at once", 1'b0, outputEnable);
        ticks(1);
        chk_word("half spacing", 16'h0000, restarts);
        ticks(3);
        chk_word("two spacings", 16'h0002, restarts);
        chk_word("used count", 16'h0002, {13'h0000, retriesUsed});
        ticks(4);
        chk_word("retries spent", 16'h0002, restarts);
        chk_bit("latched off", 1'b0, outputEnable);
        recover;
    endtask
    task test_latch;
        policy(MODE_LATCH, RETRY_FOREVER, 3'h0);
        tempReading = T_COLD;
        ticks(4);
        tempReading = T_OK;
        cycles(3);
        chk_bit("held off", 1'b0, outputEnable);
        chk_word("latch restarts", 16'h0000, restarts);
        pulse(clearStatusBit);
        cycles(3);
        chk_bit("bit clear on", 1'b1, outputEnable);
        tempReading = T_COLD;
        cycles(3);
        tempReading = T_OK;
        onCommand = 1'b0;
        cycles(3);
        onCommand = 1'b1;
        cycles(3);
        chk_bit("cycle clear on", 1'b1, outputEnable);
    endtask
    task test_forever;
        policy(MODE_OFF_RETRY, RETRY_FOREVER, 3'h0);
        tempReading = T_COLD;
        ticks(8);
        chk_word("endless retries", 16'h0008, restarts);
        onCommand = 1'b0;
        ticks(2);
        chk_word("stopped by off", 16'h0008, restarts);
        chk_bit("commanded off", 1'b0, outputEnable);
        tempReading = T_OK;
        onCommand = 1'b1;
        cycles(3);
        chk_bit("back on", 1'b1, outputEnable);
    endtask
    ////////////////////////////////////////////////////////////////////////
    // verdict and end of run
    task close_out;
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        err_total++;
        close_out;
    end
    // main sequence
    initial begin
        sys_rst = 1'b1;
        tempReading = T_OK;
        unitTick = 1'b0;
        clearFaults = 1'b0;
        clearStatusBit = 1'b0;
        onCommand = 1'b1;
        restarts = 16'h0000;
        err_total = 0;
        comparisons = 0;
        cycles(10);
        sys_rst = 1'b0;
        test_regs;
        test_ignore;
        test_run_delay;
        test_delay_retry;
        test_off_retry;
        test_latch;
        test_forever;
        close_out;
    end
endmodule // tb_top
